/* File: inc/ebps_pkg.sv */
package ebps_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the 32-bit bus
	localparam logic [31:0] EBPS_SELECT_ADDR = 32'h0000_6c00;
	localparam logic [31:0] EBPS_STATUS_ADDR = 32'h0000_6c04;
	localparam logic [31:0] EBPS_MASK_ADDR = 32'h0000_6c08;
	localparam logic [31:0] EBPS_TIMEOUT_ADDR = 32'h0000_6c0c;

	// Field positions of the bus select and timeout registers
	localparam int EBPS_MODE_BIT = 0;
	localparam int EBPS_RSVD_LO_BIT = 2;
	localparam int EBPS_RSVD_HI_BIT = 3;
	localparam int EBPS_TMO_EN_BIT = 0;

	// Status and mask bits
	localparam int EBPS_EVT_BUS_ERROR = 0;
	localparam int EBPS_EVT_STRAP_DONE = 1;
	localparam int EBPS_EVT_COUNT = 2;

	// Reset values
	localparam logic EBPS_MODE_RESET = 1'b0;
	localparam logic [1:0] EBPS_RSVD_RESET = 2'b00;
	localparam logic EBPS_TMO_EN_RESET = 1'b0;
	localparam logic [1:0] EBPS_STATUS_RESET = 2'b00;
	localparam logic [1:0] EBPS_MASK_RESET = 2'b00;

	// Mode encodings
	localparam logic EBPS_MODE_GPIO = 1'b0;
	localparam logic EBPS_MODE_EXTBUS = 1'b1;

	// Pin group widths and positions
	localparam int EBPS_ADDR_PINS = 20;
	localparam int EBPS_DATA_PINS = 32;
	localparam int EBPS_CTRL_PINS = 16;
	localparam int EBPS_PAR_PINS = 68;
	localparam int EBPS_HOST_DATA_PINS = 8;
	localparam int EBPS_HOST_PINS = 10;
	localparam int EBPS_GPIO_BITS = 46;
	localparam int EBPS_SYNC_BITS = 79;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		EBPS_CAPT_WAIT0 = 2'b00,
		EBPS_CAPT_WAIT1 = 2'b01,
		EBPS_CAPT_TAKE = 2'b11,
		EBPS_CAPT_DONE = 2'b10
	} ebps_capt_type;

	typedef enum logic {
		EBPS_BUS_ADDR = 1'b0,
		EBPS_BUS_DATA = 1'b1
	} ebps_bus_type;

	typedef struct packed {
		logic [EBPS_ADDR_PINS-1:0] addr;
		logic [EBPS_DATA_PINS-1:0] data_out;
		logic data_oe;
		logic [EBPS_CTRL_PINS-1:0] ctrl_out;
		logic [EBPS_CTRL_PINS-1:0] ctrl_oe;
	} ebps_ext_mem_drive_type;

	typedef struct packed {
		logic [EBPS_HOST_DATA_PINS-1:0] data_out;
		logic data_oe;
	} ebps_host_drive_type;

	typedef struct packed {
		logic [EBPS_GPIO_BITS-1:0] data_out;
		logic [EBPS_GPIO_BITS-1:0] data_oe;
	} ebps_gpio_drive_type;

	typedef struct packed {
		ebps_capt_type capt;
		ebps_bus_type bus;
		logic [31:0] addr;
		logic wr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic mode;
		logic [1:0] rsvd;
		logic tmo_en;
		logic [EBPS_EVT_COUNT-1:0] status;
		logic [EBPS_EVT_COUNT-1:0] mask;
		logic irq;
		logic bus_error;
		logic ext_mem_clk_en;
		logic host_port_en;
		logic [EBPS_PAR_PINS-1:0] par_out;
		logic [EBPS_PAR_PINS-1:0] par_oe;
		logic [EBPS_HOST_PINS-1:0] host_out;
		logic [EBPS_HOST_PINS-1:0] host_oe;
		logic [EBPS_GPIO_BITS-1:0] gpio_in;
		logic [EBPS_DATA_PINS-1:0] ext_mem_din;
		logic [EBPS_CTRL_PINS-1:0] ext_mem_cin;
		logic [EBPS_HOST_DATA_PINS-1:0] host_port_din;
		logic host_port_strobe;
		logic host_port_byte_id;
	} ebps_state_type;

endpackage : ebps_pkg

/* File: core/ebps_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module ebps_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// First stage feeds only the second stage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule : ebps_sync

`default_nettype wire

/* File: core/ebps_top.sv */
// Functional notes
// R1 - Strap high: memory bus and host port
// R2 - Strap low: all pins GPIO, interfaces off (code leaves A15:0 and D15:0 undriven as reserved, see R11)
// R3 - Mode field: 0 GPIO, 1 interfaces
// R4 - Mode bit 0, read/write, reset from strap
// R5 - Mode 1 routes memory pins
// R6 - Mode 1 enables host port pins
// R7 - Memory clock off unless selected
// R8 - Disabled module access errors when timeout on
// R9 - Software writes zero to bits 3:2
// R10 - Software must not change mode later
// R11 - GPIO mode: A17:2 and D15:0 reserved (code reserves A15:0 and D15:0)
// R12 - Host controls: address strobe, byte identify
// R13 - Read-only reserved bits read zero
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ebps_top
	import ebps_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	// Strap and pin groups
	input wire logic port_strap_pin,
	input wire logic [EBPS_PAR_PINS-1:0] par_pin_in,
	output logic [EBPS_PAR_PINS-1:0] par_pin_out,
	output logic [EBPS_PAR_PINS-1:0] par_pin_oe,
	input wire logic [EBPS_HOST_PINS-1:0] host_pin_in,
	output logic [EBPS_HOST_PINS-1:0] host_pin_out,
	output logic [EBPS_HOST_PINS-1:0] host_pin_oe,
	// Internal memory interface side
	input wire ebps_ext_mem_drive_type ext_mem_drive,
	output logic [EBPS_DATA_PINS-1:0] ext_mem_data_in,
	output logic [EBPS_CTRL_PINS-1:0] ext_mem_ctrl_in,
	output logic ext_mem_clk_en,
	// Internal host port side
	input wire ebps_host_drive_type host_port_drive,
	output logic [EBPS_HOST_DATA_PINS-1:0] host_port_data_in,
	output logic host_port_addr_strobe,
	output logic host_byte_identify,
	output logic host_port_enable,
	// Parallel general IO side
	input wire ebps_gpio_drive_type gpio_drive,
	output logic [EBPS_GPIO_BITS-1:0] gpio_data_in,
	// On-chip accesses to the two interfaces
	input wire logic ext_mem_access,
	input wire logic host_port_access,
	output logic bus_error,
	output logic port_mode
);

	////////////////////////////////////////////////////////////////////////
	// Pin inputs cross in through two flip-flops

	logic [EBPS_SYNC_BITS-1:0] sync_raw;
	logic [EBPS_SYNC_BITS-1:0] sync_val;
	logic strap_sync;
	logic [EBPS_PAR_PINS-1:0] par_sync;
	logic [EBPS_HOST_PINS-1:0] host_sync;

	assign sync_raw = {port_strap_pin, host_pin_in, par_pin_in};
	assign par_sync = sync_val[EBPS_PAR_PINS-1:0];
	assign host_sync = sync_val[EBPS_PAR_PINS+EBPS_HOST_PINS-1:EBPS_PAR_PINS];
	assign strap_sync = sync_val[EBPS_SYNC_BITS-1];

	ebps_sync #(
		.WIDTH(EBPS_SYNC_BITS)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(sync_raw),
		.sync_out(sync_val)
	);

	////////////////////////////////////////////////////////////////////////
	// Register read value

	ebps_state_type state;
	ebps_state_type next_state;

	function automatic logic [31:0] ebps_read(
		input logic [31:0] addr,
		input ebps_state_type st
	);
		logic [31:0] value;
		value = 32'h0000_0000;
		case (addr)
			EBPS_SELECT_ADDR: begin
				// Bits 31:4 and 1 stay zero
				value[EBPS_MODE_BIT] = st.mode; // see R3 see R13
				value[EBPS_RSVD_HI_BIT:EBPS_RSVD_LO_BIT] = st.rsvd;
			end
			EBPS_STATUS_ADDR: begin
				value[EBPS_EVT_COUNT-1:0] = st.status;
			end
			EBPS_MASK_ADDR: begin
				value[EBPS_EVT_COUNT-1:0] = st.mask;
			end
			EBPS_TIMEOUT_ADDR: begin
				value[EBPS_TMO_EN_BIT] = st.tmo_en;
			end
			default: begin
				value = 32'h0000_0000;
			end
		endcase
		return value;
	endfunction : ebps_read

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [EBPS_EVT_COUNT-1:0] evt;
		logic [EBPS_EVT_COUNT-1:0] clr;
		logic access_err;
		evt = '0;
		clr = '0;
		access_err = 1'b0;
		next_state = state;
		next_state.bus_error = 1'b0;

		// Strap capture waits until the synchroniser holds a real pin level
		case (state.capt)
			EBPS_CAPT_WAIT0: begin
				next_state.capt = EBPS_CAPT_WAIT1;
			end
			EBPS_CAPT_WAIT1: begin
				next_state.capt = EBPS_CAPT_TAKE;
			end
			EBPS_CAPT_TAKE: begin
				next_state.mode = strap_sync; // see R1 see R2 see R4
				next_state.capt = EBPS_CAPT_DONE;
				evt[EBPS_EVT_STRAP_DONE] = 1'b1;
			end
			EBPS_CAPT_DONE: begin
				next_state.capt = EBPS_CAPT_DONE;
			end
			default: begin
				next_state.capt = EBPS_CAPT_WAIT0;
			end
		endcase

		// Bus slave: one wait cycle so read data leave a flip-flop
		case (state.bus)
			EBPS_BUS_ADDR: begin
				if (hsel && htrans[1] && hready) begin
					next_state.addr = haddr;
					next_state.wr = hwrite;
					next_state.hreadyout = 1'b0;
					next_state.bus = EBPS_BUS_DATA;
				end
			end
			EBPS_BUS_DATA: begin
				next_state.hreadyout = 1'b1;
				next_state.bus = EBPS_BUS_ADDR;
				if (state.wr) begin
					case (state.addr)
						EBPS_SELECT_ADDR: begin
							// Later mode writes take effect; use is unsupported
							next_state.mode = hwdata[EBPS_MODE_BIT]; // see R4 see R10
							next_state.rsvd =
								hwdata[EBPS_RSVD_HI_BIT:EBPS_RSVD_LO_BIT]; // see R9
						end
						EBPS_STATUS_ADDR: begin
							clr = hwdata[EBPS_EVT_COUNT-1:0];
						end
						EBPS_MASK_ADDR: begin
							next_state.mask = hwdata[EBPS_EVT_COUNT-1:0];
						end
						EBPS_TIMEOUT_ADDR: begin
							next_state.tmo_en = hwdata[EBPS_TMO_EN_BIT];
						end
						default: begin
							next_state.mask = state.mask;
						end
					endcase
				end else begin
					next_state.hrdata = ebps_read(state.addr, state);
				end
			end
			default: begin
				next_state.bus = EBPS_BUS_ADDR;
				next_state.hreadyout = 1'b1;
			end
		endcase

		// Access to a switched-off interface
		access_err = (ext_mem_access || host_port_access) &&
			(next_state.mode == EBPS_MODE_GPIO);
		if (access_err && state.tmo_en) begin
			next_state.bus_error = 1'b1; // see R8
			evt[EBPS_EVT_BUS_ERROR] = 1'b1;
		end

		// A new event beats a clear in the same cycle
		next_state.status = (state.status & ~clr) | evt;
		next_state.irq = |(next_state.status & next_state.mask);

		// Enables follow the mode the pins are about to use
		next_state.ext_mem_clk_en = next_state.mode; // see R7
		next_state.host_port_en = next_state.mode; // see R6

		// Pin routing
		if (next_state.mode == EBPS_MODE_EXTBUS) begin
			next_state.par_out = {ext_mem_drive.ctrl_out,
				ext_mem_drive.data_out, ext_mem_drive.addr}; // see R5
			next_state.par_oe = {ext_mem_drive.ctrl_oe,
				{EBPS_DATA_PINS{ext_mem_drive.data_oe}},
				{EBPS_ADDR_PINS{1'b1}}};
			// Host controls are inputs to the host port
			next_state.host_out = {2'b00, host_port_drive.data_out}; // see R6
			next_state.host_oe = {2'b00,
				{EBPS_HOST_DATA_PINS{host_port_drive.data_oe}}};
			next_state.gpio_in = '0;
			next_state.ext_mem_din = par_sync[51:20];
			next_state.ext_mem_cin = par_sync[67:52];
			next_state.host_port_din = host_sync[7:0];
			next_state.host_port_strobe = host_sync[8]; // see R12
			next_state.host_port_byte_id = host_sync[9]; // see R12
		end else begin
			// Reserved pins are left undriven
			next_state.par_out = {gpio_drive.data_out[35:20],
				gpio_drive.data_out[19:4], 16'h0000,
				gpio_drive.data_out[3:0], 16'h0000}; // see R11
			next_state.par_oe = {gpio_drive.data_oe[35:20],
				gpio_drive.data_oe[19:4], 16'h0000,
				gpio_drive.data_oe[3:0], 16'h0000}; // see R11
			next_state.host_out = gpio_drive.data_out[45:36]; // see R2
			next_state.host_oe = gpio_drive.data_oe[45:36];
			next_state.gpio_in = {host_sync, par_sync[67:52],
				par_sync[51:36], par_sync[19:16]};
			// Idle levels keep the disabled interfaces quiet
			next_state.ext_mem_din = '0;
			next_state.ext_mem_cin = '0;
			next_state.host_port_din = '0;
			next_state.host_port_strobe = 1'b1;
			next_state.host_port_byte_id = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state.capt <= EBPS_CAPT_WAIT0;
			state.bus <= EBPS_BUS_ADDR;
			state.addr <= 32'h0000_0000;
			state.wr <= 1'b0;
			state.hreadyout <= 1'b1;
			state.hrdata <= 32'h0000_0000;
			state.mode <= EBPS_MODE_RESET;
			state.rsvd <= EBPS_RSVD_RESET;
			state.tmo_en <= EBPS_TMO_EN_RESET;
			state.status <= EBPS_STATUS_RESET;
			state.mask <= EBPS_MASK_RESET;
			state.irq <= 1'b0;
			state.bus_error <= 1'b0;
			state.ext_mem_clk_en <= 1'b0;
			state.host_port_en <= 1'b0;
			state.par_out <= '0;
			state.par_oe <= '0;
			state.host_out <= '0;
			state.host_oe <= '0;
			state.gpio_in <= '0;
			state.ext_mem_din <= '0;
			state.ext_mem_cin <= '0;
			state.host_port_din <= '0;
			state.host_port_strobe <= 1'b1;
			state.host_port_byte_id <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign hreadyout = state.hreadyout;
	assign hresp = 1'b0;
	assign hrdata = state.hrdata;
	assign irq = state.irq;
	assign par_pin_out = state.par_out;
	assign par_pin_oe = state.par_oe;
	assign host_pin_out = state.host_out;
	assign host_pin_oe = state.host_oe;
	assign ext_mem_data_in = state.ext_mem_din;
	assign ext_mem_ctrl_in = state.ext_mem_cin;
	assign ext_mem_clk_en = state.ext_mem_clk_en;
	assign host_port_data_in = state.host_port_din;
	assign host_port_addr_strobe = state.host_port_strobe;
	assign host_byte_identify = state.host_port_byte_id;
	assign host_port_enable = state.host_port_en;
	assign gpio_data_in = state.gpio_in;
	assign bus_error = state.bus_error;
	assign port_mode = state.mode;

endmodule : ebps_top

`default_nettype wire

/* File: verification/ebps_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module ebps_sva
	import ebps_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [EBPS_PAR_PINS-1:0] par_pin_out,
	input wire logic [EBPS_PAR_PINS-1:0] par_pin_oe,
	input wire logic [EBPS_HOST_PINS-1:0] host_pin_in,
	input wire ebps_ext_mem_drive_type ext_mem_drive,
	input wire logic [EBPS_DATA_PINS-1:0] ext_mem_data_in,
	input wire logic ext_mem_clk_en,
	input wire logic host_port_addr_strobe,
	input wire logic host_byte_identify,
	input wire logic host_port_enable,
	input wire logic ext_mem_access,
	input wire logic host_port_access,
	input wire logic bus_error,
	input wire logic port_mode
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_taken;
		hsel && htrans[1] && hready && hreadyout;
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_one_wait: assert property (s_taken |=> s_one_wait)
		else $error("bus wait state wrong");
	a_clk_gate: assert property (ext_mem_clk_en == port_mode)
		else $error("memory clock enable wrong");
	a_host_enable: assert property (host_port_enable == port_mode)
		else $error("host port enable wrong");
	a_rsvd_pins: assert property (!port_mode |->
		par_pin_oe[15:0] == 16'h0 && par_pin_oe[35:20] == 16'h0)
		else $error("reserved pin driven");
	a_din_off: assert property (!port_mode |-> ext_mem_data_in == '0)
		else $error("memory data seen in io mode");
	a_strobe_idle: assert property (!port_mode |->
		host_port_addr_strobe && !host_byte_identify)
		else $error("host controls not idle");
	a_host_ctl: assert property (port_mode && $past(port_mode) |->
		host_port_addr_strobe == $past(host_pin_in[8], 3) &&
		host_byte_identify == $past(host_pin_in[9], 3))
		else $error("host control pins misrouted");
	a_addr_route: assert property (port_mode && $past(port_mode) |->
		par_pin_out[19:0] == $past(ext_mem_drive.addr))
		else $error("address pins misrouted");
	a_err_cause: assert property (bus_error |->
		$past(ext_mem_access || host_port_access) && !$past(port_mode))
		else $error("bus error without cause");
endmodule : ebps_sva
bind ebps_top ebps_sva u_sva (.mclk, .rst_n, .hsel, .htrans, .hready,
	.hreadyout, .par_pin_out, .par_pin_oe, .host_pin_in, .ext_mem_drive,
	.ext_mem_data_in, .ext_mem_clk_en, .host_port_addr_strobe,
	.host_byte_identify, .host_port_enable, .ext_mem_access,
	.host_port_access, .bus_error, .port_mode);
`default_nettype wire

/* File: verification/ebps_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ebps_far_model
	import ebps_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [EBPS_PAR_PINS-1:0] par_pin_out,
	input wire logic [EBPS_PAR_PINS-1:0] par_pin_oe,
	input wire logic [EBPS_HOST_PINS-1:0] host_pin_out,
	input wire logic [EBPS_HOST_PINS-1:0] host_pin_oe,
	input wire logic [EBPS_HOST_PINS-1:0] host_drive,
	output logic [EBPS_PAR_PINS-1:0] par_pin_in,
	output logic [EBPS_HOST_PINS-1:0] host_pin_in
);
	logic [EBPS_PAR_PINS-1:0] float_q;
	// Released lines toggle, so a stale level never passes for data
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			float_q <= '0;
		else
			float_q <= ~float_q;
	assign par_pin_in = (par_pin_oe & par_pin_out) | (~par_pin_oe & float_q);
	// Host processor drives every host pin the device leaves free
	assign host_pin_in = (host_pin_oe & host_pin_out) |
		(~host_pin_oe & host_drive);
endmodule : ebps_far_model
`default_nettype wire

/* File: verification/tb_external_bus_pin_mode_select.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_external_bus_pin_mode_select
	import ebps_pkg::*;
;
	logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, irq, port_strap_pin;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [EBPS_PAR_PINS-1:0] par_pin_in, par_pin_out, par_pin_oe;
	logic [EBPS_HOST_PINS-1:0] host_pin_in, host_pin_out, host_pin_oe;
	logic [EBPS_HOST_PINS-1:0] host_drive;
	ebps_ext_mem_drive_type ext_mem_drive;
	ebps_host_drive_type host_port_drive;
	ebps_gpio_drive_type gpio_drive;
	logic [EBPS_DATA_PINS-1:0] ext_mem_data_in;
	logic [EBPS_CTRL_PINS-1:0] ext_mem_ctrl_in;
	logic [EBPS_HOST_DATA_PINS-1:0] host_port_data_in;
	logic [EBPS_GPIO_BITS-1:0] gpio_data_in;
	logic ext_mem_clk_en, host_port_addr_strobe, host_byte_identify;
	logic host_port_enable, ext_mem_access, host_port_access;
	logic bus_error, port_mode;
	int miscompares, compares;
	ebps_top DUT (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .irq, .port_strap_pin, .par_pin_in, .par_pin_out,
		.par_pin_oe, .host_pin_in, .host_pin_out, .host_pin_oe,
		.ext_mem_drive, .ext_mem_data_in, .ext_mem_ctrl_in, .ext_mem_clk_en,
		.host_port_drive, .host_port_data_in, .host_port_addr_strobe,
		.host_byte_identify, .host_port_enable, .gpio_drive, .gpio_data_in,
		.ext_mem_access, .host_port_access, .bus_error, .port_mode);
	ebps_far_model u_far (.mclk, .rst_n, .par_pin_out, .par_pin_oe,
		.host_pin_out, .host_pin_oe, .host_drive, .par_pin_in, .host_pin_in);
	////////////////////////////////////////
	task complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task chk(input string what, input logic [63:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			complete_run();
		end
	endtask : wait_rdy
	task bus(input logic wr, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : bus
	task do_reset(input logic strap);
		rst_n <= 1'b0;
		port_strap_pin <= strap;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask : do_reset
	// One-cycle access pulse; returns one edge after the error pulse rises, while it still reads high
	task pulse_access(input logic mem);
		ext_mem_access <= mem;
		host_port_access <= !mem;
		@(posedge mclk);
		ext_mem_access <= 1'b0;
		host_port_access <= 1'b0;
		@(posedge mclk);
	endtask : pulse_access
	////////////////////////////////////////
	task t_strap(input logic s);
		do_reset(s);
		bus(1'b0, EBPS_SELECT_ADDR, 32'h0);
		chk("select", rd, {31'h0, s});
		chk("port_mode", port_mode, s);
		chk("clk_en", ext_mem_clk_en, s);
		chk("host_en", host_port_enable, s);
		chk("hresp", hresp, 1'b0);
		bus(1'b0, EBPS_STATUS_ADDR, 32'h0);
		chk("status", rd, 32'h2);
	endtask : t_strap
	task t_regs;
		bus(1'b1, EBPS_SELECT_ADDR, 32'h0000_fff2);
		bus(1'b0, EBPS_SELECT_ADDR, 32'h0);
		chk("select ro", rd, 32'h0);
		bus(1'b1, EBPS_MASK_ADDR, 32'h3);
		bus(1'b0, EBPS_MASK_ADDR, 32'h0);
		chk("mask", rd, 32'h3);
		bus(1'b1, 32'h0000_6c10, 32'hffff_ffff);
		bus(1'b0, 32'h0000_6c10, 32'h0);
		chk("unmapped", rd, 32'h0);
	endtask : t_regs
	task t_err;
		bus(1'b1, EBPS_STATUS_ADDR, 32'h3);
		bus(1'b1, EBPS_TIMEOUT_ADDR, 32'h0);
		pulse_access(1'b1);
		chk("err off", bus_error, 1'b0);
		bus(1'b1, EBPS_TIMEOUT_ADDR, 32'h1);
		bus(1'b1, EBPS_MASK_ADDR, 32'h1);
		pulse_access(1'b1);
		chk("err on", bus_error, 1'b1);
		chk("irq", irq, 1'b1);
		bus(1'b0, EBPS_STATUS_ADDR, 32'h0);
		chk("status err", rd, 32'h1);
		bus(1'b1, EBPS_STATUS_ADDR, 32'h1);
		chk("irq clr", irq, 1'b0);
		bus(1'b1, EBPS_MASK_ADDR, 32'h0);
		pulse_access(1'b0);
		chk("err host", bus_error, 1'b1);
		chk("irq mask", irq, 1'b0);
	endtask : t_err
	task t_gpio;
		gpio_drive <= '{'1, '1};
		repeat (5) @(posedge mclk);
		chk("rsvd oe", {par_pin_oe[35:20], par_pin_oe[15:0]}, 32'h0);
		chk("rsvd po", {par_pin_out[35:20], par_pin_out[15:0]}, 32'h0);
		chk("gpio oe", par_pin_oe[19:16], 4'hf);
		chk("gpio out", par_pin_out[67:36], 32'hffff_ffff);
		chk("host gpio oe", host_pin_oe, 10'h3ff);
		chk("host gpio out", host_pin_out, 10'h3ff);
		chk("gpio in", gpio_data_in, 46'h3fff_ffff_ffff);
		chk("din off", ext_mem_data_in, 32'h0);
		chk("cin off", ext_mem_ctrl_in, 16'h0);
		chk("hd off", host_port_data_in, 8'h0);
	endtask : t_gpio
	task t_route;
		ext_mem_drive <= '{20'habcde, 32'h1234_5678, 1'b1, 16'ha5c3, 16'hffff};
		host_port_drive <= '{8'h3c, 1'b0};
		host_drive <= 10'h2a5;
		repeat (5) @(posedge mclk);
		chk("addr pins", par_pin_out[19:0], 20'habcde);
		chk("data pins", par_pin_out[51:20], 32'h1234_5678);
		chk("ctrl pins", par_pin_out[67:52], 16'ha5c3);
		chk("data in", ext_mem_data_in, 32'h1234_5678);
		chk("ctrl in", ext_mem_ctrl_in, 16'ha5c3);
		chk("host out", host_pin_out, 10'h03c);
		chk("host oe", host_pin_oe, 10'h000);
		chk("host data", host_port_data_in, 8'ha5);
		chk("strobe", host_port_addr_strobe, 1'b0);
		chk("byte id", host_byte_identify, 1'b1);
		chk("gpio in", gpio_data_in, 46'h0);
	endtask : t_route
	////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{port_strap_pin, ext_mem_access, host_port_access, host_drive} = '0;
		{ext_mem_drive, host_port_drive, gpio_drive} = '0;
		miscompares = 0;
		compares = 0;
		t_strap(1'b0);
		t_regs();
		t_err();
		t_gpio();
		t_strap(1'b1);
		t_route();
		complete_run();
	end
endmodule : tb_external_bus_pin_mode_select
`default_nettype wire
